// File: hw/sffe_engine.sv
// spi frame format engine: axi4-lite registers, master and slave frame sequencing
//
// Behaviour
// - idle serial clock rests at the polarity bit value.
// - phase 0 samples on first clock transition, phase 1 on the second.
// - idle keeps frame select high and transmit line low.
// - master enables clock pad; slave leaves it disabled as input.
// - frame starts when enabled with transmit data; select low, tx enabled.
// - pol0 pha0: first bit half period after select falls, rise half later.
// - pol0 pha0: sample on rising edges, change on falling edges.
// - phase 1: first bits and first clock transition half period after select falls.
// - pol0 pha1: first clock transition is rising, with data launch.
// - pol0 pha1: sample on falling edges, change on rising edges.
// - pol1 pha0: first bit after half period, clock falls half later.
// - pol1 pha1: first clock transition is falling, with data launch.
// - pol1 pha1: sample on rising edges, change on falling edges.
// - select returns high one clock period after last bit sampled.
// - phase 0 back-to-back words get a select high pulse between them.
// - phase 1 back-to-back words keep select low until run ends.
// - words are 4 to 16 bits, most significant bit first.
// - clock is system clock over even prescale times one plus rate.
// - clock idles when port idle, toggles only during a word.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/100ps
module sffe_engine import sffe_pkg::*; #(
	parameter int WORD_W = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [`SFFE_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`SFFE_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_clock_in,
	output logic serial_clock_out,
	output logic serial_clock_oe,
	input wire logic frame_select_in,
	output logic frame_select_out,
	output logic frame_select_oe,
	output logic serial_tx_line,
	output logic serial_tx_oe,
	input wire logic serial_rx_line
);
	localparam int CW = $clog2(WORD_W + 1);
	localparam int SW = $clog2(2 * WORD_W + 3);

	if (WORD_W < 4 || WORD_W > 16) begin : g_bad_word
		$error("sffe_engine: word width must lie between 4 and 16");
	end

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic aw_got;
		logic [`SFFE_ADDR_W-1:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [15:0] ctrl0;
		logic [2:0] ctrl1;
		logic [7:0] presc;
		sffe_state_t st;
		logic [15:0] div;
		logic [SW-1:0] step;
		logic [CW-1:0] bits;
		logic [WORD_W-1:0] txsh;
		logic [WORD_W-1:0] rxsh;
		logic [WORD_W-1:0] tx_hold;
		logic tx_valid;
		logic [WORD_W-1:0] rx_data;
		logic rx_valid;
		logic sclk;
		logic sclk_oe;
		logic fss;
		logic fss_oe;
		logic tx;
		logic tx_oe;
		logic prev_sclk;
		logic sel;
		logic first;
	} sffe_regs_t;

	sffe_regs_t r;
	sffe_regs_t n;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] sffe_merge(input logic [31:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// half a serial clock period in system clocks; a zero prescale acts as the smallest one
	function automatic logic [15:0] sffe_half(input logic [7:0] presc, input logic [7:0] rate);
		logic [6:0] p;
		p = (presc[7:1] == 7'h00) ? `SFFE_MIN_HALF : presc[7:1];
		return 16'(p) * (16'(rate) + 16'h0001);
	endfunction

	logic sclk_s;
	logic fss_s;
	logic rx_s;

	// pins from the far side pass three flops; this costs three cycles of sampling latency
	sffe_sync3 #(
		.W(3),
		.RST_VAL(`SFFE_SYNC_RST)
	) u_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.pin_in({serial_clock_in, frame_select_in, serial_rx_line}),
		.level_out({sclk_s, fss_s, rx_s})
	);

	logic pol;
	logic pha;
	logic en;
	logic slv;
	logic [3:0] size_f;
	logic [CW-1:0] nbits;
	logic [SW-1:0] two_n;
	logic [SW-1:0] end_step;
	logic [15:0] half;
	logic tick;
	logic [SW-1:0] s;
	logic [SW-1:0] e;
	logic toggle;
	logic sample;
	logic shift_now;
	logic last_bit;
	logic [WORD_W-1:0] load_word;
	logic [WORD_W-1:0] rx_next;
	logic [WORD_W-1:0] rx_mask;
	logic smp_edge;
	logic sh_edge;
	logic [31:0] wm;
	logic [31:0] stat;

	always_comb begin
		pol = r.ctrl0[`SFFE_C0_POL];
		pha = r.ctrl0[`SFFE_C0_PHA];
		en = r.ctrl1[`SFFE_C1_EN];
		slv = r.ctrl1[`SFFE_C1_SLV];
		size_f = (r.ctrl0[`SFFE_C0_SIZE_HI:0] < `SFFE_MIN_SIZE) ? `SFFE_MIN_SIZE : r.ctrl0[`SFFE_C0_SIZE_HI:0];
		nbits = CW'(size_f) + CW'(1);
		two_n = SW'(nbits) + SW'(nbits);
		end_step = two_n + SW'(`SFFE_END_EXTRA);
		half = sffe_half(r.presc, r.ctrl0[`SFFE_C0_RATE_HI:`SFFE_C0_RATE_LO]);
		tick = (r.div >= half - 16'h0001);
		s = r.step + SW'(1);
		// edge index: phase 0 holds the clock one extra half period before its first edge
		e = s - SW'(!pha);
		toggle = (e != '0) && (e <= two_n);
		sample = toggle && (e[0] ^ pha);
		shift_now = toggle && !sample && (s != SW'(1)) && (e < two_n);
		last_bit = (r.bits == nbits - CW'(1));
		// msb first: short words are left aligned in the shifter
		load_word = r.tx_valid ? (r.tx_hold << (WORD_W - int'(nbits))) : '0;
		// bits above the word size are cleared so a shorter word never carries older bits
		rx_mask = ~({WORD_W{1'b1}} << nbits);
		rx_next = {r.rxsh[WORD_W-2:0], rx_s} & rx_mask;
		smp_edge = (pol == pha) ? (sclk_s && !r.prev_sclk) : (!sclk_s && r.prev_sclk);
		sh_edge = (pol == pha) ? (!sclk_s && r.prev_sclk) : (sclk_s && !r.prev_sclk);
		wm = sffe_merge({16'h0000, r.ctrl0}, r.wdata, r.wstrb);
		stat = '0;
		stat[`SFFE_ST_TXE] = !r.tx_valid;
		stat[`SFFE_ST_TXNF] = !r.tx_valid;
		stat[`SFFE_ST_RXV] = r.rx_valid;
		stat[`SFFE_ST_BUSY] = (r.st == SFFE_RUN) || (r.st == SFFE_GAP) || r.sel;

		n = r;
		// ----------------------------------------------------------------
		// axi4-lite slave
		// ----------------------------------------------------------------
		if (r.awready && s_axi_awvalid) begin
			n.aw_got = 1'b1;
			n.awaddr = s_axi_awaddr;
		end
		if (r.wready && s_axi_wvalid) begin
			n.w_got = 1'b1;
			n.wdata = s_axi_wdata;
			n.wstrb = s_axi_wstrb;
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (r.aw_got && r.w_got && !r.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = `SFFE_RESP_OKAY;
			case (r.awaddr)
				`SFFE_OFS_CTRL0: n.ctrl0 = wm[15:0];
				`SFFE_OFS_CTRL1: n.ctrl1 = 3'(sffe_merge(32'(r.ctrl1), r.wdata, r.wstrb)) & `SFFE_C1_MASK;
				`SFFE_OFS_PRESC: n.presc = 8'(sffe_merge(32'(r.presc), r.wdata, r.wstrb)) & `SFFE_PRESC_MASK;
				`SFFE_OFS_DATA: begin
					// a write to a full holding register is dropped; status shows it full
					if (!r.tx_valid) begin
						n.tx_hold = WORD_W'(r.wdata);
						n.tx_valid = 1'b1;
					end
				end
				`SFFE_OFS_STAT: n.bresp = `SFFE_RESP_OKAY;
				default: n.bresp = `SFFE_RESP_SLVERR;
			endcase
		end
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (r.arready && s_axi_arvalid) begin
			n.rvalid = 1'b1;
			n.rresp = `SFFE_RESP_OKAY;
			case (s_axi_araddr)
				`SFFE_OFS_CTRL0: n.rdata = 32'(r.ctrl0);
				`SFFE_OFS_CTRL1: n.rdata = 32'(r.ctrl1);
				`SFFE_OFS_PRESC: n.rdata = 32'(r.presc);
				`SFFE_OFS_STAT: n.rdata = stat;
				`SFFE_OFS_DATA: begin
					n.rdata = 32'(r.rx_data);
					n.rx_valid = 1'b0;
				end
				default: begin
					n.rdata = '0;
					n.rresp = `SFFE_RESP_SLVERR;
				end
			endcase
		end
		n.arready = !n.rvalid;
		n.awready = !n.aw_got;
		n.wready = !n.w_got;

		// ----------------------------------------------------------------
		// frame engine (runs after the bus so a completed word beats a read clear)
		// ----------------------------------------------------------------
		n.sclk_oe = !slv;
		n.fss_oe = !slv;
		unique case (r.st)
			SFFE_IDLE: begin
				n.sclk = pol;
				n.fss = `SFFE_FSS_IDLE;
				n.tx = `SFFE_TX_IDLE;
				n.tx_oe = en && !slv;
				n.div = '0;
				n.step = '0;
				n.bits = '0;
				n.sel = 1'b0;
				n.prev_sclk = sclk_s;
				if (en && slv) begin
					n.st = SFFE_SLAVE;
				end else if (en && r.tx_valid) begin
					n.st = SFFE_RUN;
					n.fss = 1'b0;
					n.tx_oe = 1'b1;
					n.txsh = load_word;
					n.tx_valid = 1'b0;
				end
			end
			SFFE_RUN: begin
				if (!en || slv) begin
					n.st = SFFE_IDLE;
					n.fss = `SFFE_FSS_IDLE;
					n.sclk = pol;
					n.tx = `SFFE_TX_IDLE;
				end else if (tick) begin
					n.div = '0;
					n.step = s;
					if (toggle) begin
						n.sclk = !r.sclk;
					end
					if (s == SW'(1)) begin
						n.tx = r.txsh[WORD_W-1];
					end
					if (shift_now) begin
						n.txsh = r.txsh << 1;
						n.tx = r.txsh[WORD_W-2];
					end
					if (sample) begin
						n.rxsh = rx_next;
						if (last_bit) begin
							n.rx_data = rx_next;
							n.rx_valid = 1'b1;
							n.bits = '0;
						end else begin
							n.bits = r.bits + CW'(1);
						end
					end
					if (s == end_step) begin
						n.step = '0;
						if (r.tx_valid && pha) begin
							n.txsh = load_word;
							n.tx_valid = 1'b0;
						end else begin
							n.fss = `SFFE_FSS_IDLE;
							n.tx = `SFFE_TX_IDLE;
							n.st = r.tx_valid ? SFFE_GAP : SFFE_IDLE;
						end
					end
				end else begin
					n.div = r.div + 16'h0001;
				end
			end
			SFFE_GAP: begin
				// select stays high for half a clock period between phase 0 words
				if (!en || slv) begin
					n.st = SFFE_IDLE;
				end else if (tick) begin
					n.div = '0;
					n.step = '0;
					n.st = SFFE_RUN;
					n.fss = 1'b0;
					n.txsh = load_word;
					n.tx_valid = 1'b0;
				end else begin
					n.div = r.div + 16'h0001;
				end
			end
			SFFE_SLAVE: begin
				n.prev_sclk = sclk_s;
				n.sclk = pol;
				if (!en || !slv) begin
					n.st = SFFE_IDLE;
					n.sel = 1'b0;
					n.tx_oe = 1'b0;
					n.tx = `SFFE_TX_IDLE;
				end else if (fss_s) begin
					n.sel = 1'b0;
					n.tx_oe = 1'b0;
					n.tx = `SFFE_TX_IDLE;
				end else if (!r.sel) begin
					// an empty holding register sends zeros
					n.sel = 1'b1;
					n.tx_oe = 1'b1;
					n.bits = '0;
					n.first = pha;
					if (!pha) begin
						n.txsh = load_word;
						n.tx = load_word[WORD_W-1];
						n.tx_valid = 1'b0;
					end
				end else begin
					if (sh_edge) begin
						if (r.first) begin
							n.txsh = load_word;
							n.tx = load_word[WORD_W-1];
							n.tx_valid = 1'b0;
							n.first = 1'b0;
						end else begin
							n.txsh = r.txsh << 1;
							n.tx = r.txsh[WORD_W-2];
						end
					end
					if (smp_edge) begin
						n.rxsh = rx_next;
						if (last_bit) begin
							n.rx_data = rx_next;
							n.rx_valid = 1'b1;
							n.bits = '0;
							n.first = pha;
						end else begin
							n.bits = r.bits + CW'(1);
						end
					end
				end
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			r <= '0;
			r.fss <= `SFFE_FSS_IDLE;
			r.sclk_oe <= 1'b1;
			r.fss_oe <= 1'b1;
			r.ctrl0 <= `SFFE_RST_CTRL0;
			r.ctrl1 <= `SFFE_RST_CTRL1;
			r.presc <= `SFFE_RST_PRESC;
		end else begin
			r <= n;
		end
	end

	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bresp = r.bresp;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_arready = r.arready;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rvalid = r.rvalid;
	assign serial_clock_out = r.sclk;
	assign serial_clock_oe = r.sclk_oe;
	assign frame_select_out = r.fss;
	assign frame_select_oe = r.fss_oe;
	assign serial_tx_line = r.tx;
	assign serial_tx_oe = r.tx_oe;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	sequence seq_launch;
		(r.st == SFFE_RUN) && (r.step == SW'(1)) && (r.step != $past(r.step));
	endsequence

	sequence seq_word_end;
		($past(r.st) == SFFE_RUN) && !$past(r.fss) && r.fss;
	endsequence

	chk_idle_clock_level: assert property (
		(r.st == SFFE_IDLE && $past(r.st) == SFFE_IDLE) |-> (r.sclk == $past(r.ctrl0[`SFFE_C0_POL])))
		else $error("idle clock not at polarity level");
	chk_idle_lines: assert property (
		(r.st == SFFE_IDLE) |-> (r.fss && !r.tx))
		else $error("idle select or transmit line wrong");
	chk_clock_pad_role: assert property (
		r.sclk_oe == !$past(r.ctrl1[`SFFE_C1_SLV]))
		else $error("clock pad enable does not follow role");
	chk_frame_start: assert property (
		(!r.fss && $past(r.fss) && r.st == SFFE_RUN) |->
		($past(r.tx_valid) && $past(r.ctrl1[`SFFE_C1_EN]) && r.tx_oe))
		else $error("frame opened without enable or data");
	chk_first_edge: assert property (
		seq_launch |-> ((r.sclk != r.ctrl0[`SFFE_C0_POL]) == r.ctrl0[`SFFE_C0_PHA]) &&
		(r.tx == $past(r.txsh[WORD_W-1])))
		else $error("first launch or first clock edge misplaced");
	chk_gap_quiet: assert property (
		(r.st == SFFE_GAP) |-> (r.fss && !$past(r.ctrl0[`SFFE_C0_PHA]) && (r.sclk == $past(r.sclk))))
		else $error("gap between words malformed");
	chk_run_held_low: assert property (
		(r.st == SFFE_RUN && $past(r.st) == SFFE_RUN && $past(r.ctrl1[`SFFE_C1_EN])) |-> !r.fss)
		else $error("select left low state inside a run");
	chk_release_step: assert property (
		(seq_word_end and ($past(r.ctrl1[`SFFE_C1_EN]) && !$past(r.ctrl1[`SFFE_C1_SLV]))) |->
		($past(s) == $past(end_step)) && $past(tick) && (r.sclk == $past(r.ctrl0[`SFFE_C0_POL])))
		else $error("select released at the wrong step");
	chk_div_bound: assert property (
		(r.st == SFFE_RUN && half == $past(half) && $past(r.st) == SFFE_RUN) |-> (r.div < half))
		else $error("divider ran past half period");
	chk_rx_set_wins: assert property (
		(r.st == SFFE_RUN && tick && sample && last_bit && en && !slv) |=> r.rx_valid)
		else $error("completed word lost");
endmodule // sffe_engine

// File: hw/sffe_regs.svh
// register offsets, field positions, reset values and timing constants of the spi frame engine
`ifndef SFFE_REGS_SVH
`define SFFE_REGS_SVH
// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define SFFE_ADDR_W 12
`define SFFE_OFS_CTRL0 12'h000
`define SFFE_OFS_CTRL1 12'h004
`define SFFE_OFS_DATA 12'h008
`define SFFE_OFS_STAT 12'h00C
`define SFFE_OFS_PRESC 12'h010
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SFFE_C0_SIZE_HI 3
`define SFFE_C0_POL 6
`define SFFE_C0_PHA 7
`define SFFE_C0_RATE_LO 8
`define SFFE_C0_RATE_HI 15
`define SFFE_C1_EN 1
`define SFFE_C1_SLV 2
`define SFFE_C1_MASK 3'h6
`define SFFE_PRESC_MASK 8'hFE
`define SFFE_ST_TXE 0
`define SFFE_ST_TXNF 1
`define SFFE_ST_RXV 2
`define SFFE_ST_BUSY 4
// ----------------------------------------------------------------
// reset values, limits and answers
// ----------------------------------------------------------------
`define SFFE_RST_CTRL0 16'h0000
`define SFFE_RST_CTRL1 3'h0
`define SFFE_RST_PRESC 8'h00
`define SFFE_MIN_SIZE 4'h3
`define SFFE_MIN_HALF 7'h01
`define SFFE_END_EXTRA 2
`define SFFE_RESP_OKAY 2'h0
`define SFFE_RESP_SLVERR 2'h2
`define SFFE_FSS_IDLE 1'b1
`define SFFE_TX_IDLE 1'b0
`define SFFE_SYNC_RST 3'h2
`endif

// File: hw/sffe_pkg.sv
// types shared by the spi frame engine files
package sffe_pkg;
	`include "sffe_regs.svh"
	typedef enum logic [1:0] {SFFE_IDLE, SFFE_RUN, SFFE_GAP, SFFE_SLAVE} sffe_state_t;
endpackage

// File: hw/sffe_sync3.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/100ps
module sffe_sync3 import sffe_pkg::*; #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} sffe_sync_t;

	sffe_sync_t st_r;
	sffe_sync_t st_nxt;

	if (W < 1) begin : g_bad_width
		$error("sffe_sync3: width must be at least one");
	end

	// a change only counts once the second and third stages agree
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = pin_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.lvl = (~(st_r.s2 ^ st_r.s3) & st_r.s3) | ((st_r.s2 ^ st_r.s3) & st_r.lvl);
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st_r <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			st_r <= st_nxt;
		end
	end

	// the agreed level leaves straight from the second and third stages, so the far side sees
	// three cycles of latency rather than four; the held level only bridges disagreement
	assign level_out = st_nxt.lvl;

	chk_level_agree: assert property (@(posedge sys_clk) disable iff (rst)
		(st_r.lvl != $past(st_r.lvl)) |-> ($past(st_r.s2) == $past(st_r.s3)))
		else $error("synchronised level changed without agreement");
endmodule // sffe_sync3

// File: bench/sffe_spi_partner.sv
// behavioural spi partner standing on the far side of the serial pins
`timescale 1ns/100ps
module sffe_spi_partner (
	input wire logic sclk,
	input wire logic sel_n,
	input wire logic mosi,
	input wire logic pol,
	input wire logic pha,
	input wire logic [4:0] nbits,
	input wire logic [15:0] reply,
	output logic miso,
	output logic [15:0] got
);
	int cnt = 0;
	task automatic put_bit();
		if (cnt >= nbits) cnt = 0;
		miso = reply[nbits - 1 - cnt];
		cnt++;
	endtask
	initial begin
		miso = 1'b0;
		got = 16'h0000;
	end
	always @(negedge sel_n) begin
		cnt = 0;
		got = 16'h0000;
		if (!pha) put_bit();
	end
	// no pull on the line, so a released line shows the inverse of its last bit
	always @(posedge sel_n) miso = ~miso;
	always @(sclk) begin
		if (sel_n === 1'b0 && ((sclk !== pol) ^ pha)) got = {got[14:0], mosi};
		else if (sel_n === 1'b0) put_bit();
	end
endmodule // sffe_spi_partner

// File: bench/sffe_engine_tb.sv
// self-checking bench of the spi frame engine against a behavioural partner
`timescale 1ns/100ps
`include "sffe_regs.svh"
`define SFFE_CHK(nm, ex, sn) begin checked++; if ((sn) !== (ex)) begin bad_count++; \
	$display("mismatch %s expected %0h seen %0h", nm, ex, sn); end end
module sffe_engine_tb import sffe_pkg::*;;
	localparam logic [15:0] REPLY = 16'hB6D9;
	localparam logic [1:0] OK = `SFFE_RESP_OKAY;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic sclk_in = 1'b0, fss_in = 1'b1, slv = 1'b0;
	logic serial_clock_out, serial_clock_oe, frame_select_out, frame_select_oe, serial_tx_line, serial_tx_oe;
	logic serial_rx_line, m_pol = 0, m_pha = 0, first_lvl, fss_d = 1, sclk_d = 0;
	logic [4:0] m_n = 5'h08;
	logic [15:0] got;
	int bad_count = 0, checked = 0, togs = 0, falls = 0, hi_run = 0, first_dly = -1, since = 0, low_len = 0;
	wire m_sclk = slv ? sclk_in : serial_clock_out;
	wire m_fss = slv ? fss_in : frame_select_out;

	always #2 sys_clk = ~sys_clk;

	sffe_engine dut (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .serial_clock_in(sclk_in),
		.serial_clock_out, .serial_clock_oe, .frame_select_in(fss_in), .frame_select_out, .frame_select_oe,
		.serial_tx_line, .serial_tx_oe, .serial_rx_line);
	sffe_spi_partner partner (.sclk(m_sclk), .sel_n(m_fss), .mosi(serial_tx_line), .pol(m_pol), .pha(m_pha),
		.nbits(m_n), .reply(REPLY), .miso(serial_rx_line), .got(got));

	// ----------------------------------------------------------------
	// wire monitor
	// ----------------------------------------------------------------
	always @(posedge sys_clk) begin
		if (fss_d === 1'b1 && frame_select_out === 1'b0) begin
			falls++;
			since = 0;
		end else since++;
		if (serial_clock_out !== sclk_d) togs++;
		if (serial_clock_out !== sclk_d && first_dly < 0) begin
			first_dly = since;
			first_lvl = serial_clock_out;
		end
		if (frame_select_out === 1'b0) low_len++;
		hi_run = (frame_select_out === 1'b1) ? hi_run + 1 : 0;
		fss_d = frame_select_out;
		sclk_d = serial_clock_out;
	end

	// ----------------------------------------------------------------
	// bus and wait tasks
	// ----------------------------------------------------------------
	task automatic tally_and_finish();
		if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge sys_clk);
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
			if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		if (n >= 100) bad_count++;
		if (n >= 100) tally_and_finish();
		`SFFE_CHK("bresp", er, s_axi_bresp)
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex, input logic [1:0] er);
		int n;
		@(posedge sys_clk);
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			n++;
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 100);
		s_axi_rready <= 1'b0;
		if (n >= 100) bad_count++;
		if (n >= 100) tally_and_finish();
		`SFFE_CHK("rresp", er, s_axi_rresp)
		`SFFE_CHK("rdata", ex, s_axi_rdata)
	endtask
	task automatic wait_for(input int f, input int hi);
		int n;
		n = 0;
		while ((falls < f || hi_run < hi) && n < 3000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n >= 3000) bad_count++;
		if (n >= 3000) tally_and_finish();
	endtask

	// ----------------------------------------------------------------
	// one master frame, or two back to back; half period is 4 cycles
	// ----------------------------------------------------------------
	task automatic frame_test(input logic p, input logic h, input logic [4:0] n, input logic [7:0] psc,
		input logic [7:0] rt, input logic [15:0] w, input logic two);
		logic [15:0] mk;
		logic [31:0] c0;
		mk = 16'hFFFF >> (16 - n);
		c0 = {16'h0000, rt, h, p, 2'h0, n[3:0] - 4'h1};
		m_pol <= p;
		m_pha <= h;
		m_n <= n;
		axi_wr(`SFFE_OFS_CTRL1, 32'h0, OK);
		axi_wr(`SFFE_OFS_PRESC, {24'h0, psc}, OK);
		axi_wr(`SFFE_OFS_CTRL0, c0, OK);
		rd_chk(`SFFE_OFS_CTRL0, c0, OK);
		axi_wr(`SFFE_OFS_DATA, {16'h0, w}, OK);
		`SFFE_CHK("sclk idle", p, serial_clock_out)
		togs = 0;
		falls = 0;
		low_len = 0;
		first_dly = -1;
		repeat (12) @(posedge sys_clk);
		`SFFE_CHK("falls off", 0, falls)
		axi_wr(`SFFE_OFS_CTRL1, 32'h2, OK);
		`SFFE_CHK("clock oe", 1'b1, serial_clock_oe)
		if (two) wait_for(1, 0);
		if (two) axi_wr(`SFFE_OFS_DATA, {16'h0, w ^ mk}, OK);
		wait_for((two && !h) ? 2 : 1, 8);
		`SFFE_CHK("falls", (two && !h) ? 2 : 1, falls)
		`SFFE_CHK("toggles", (two ? 4 : 2) * n, togs)
		`SFFE_CHK("first edge", h ? 4 : 8, first_dly)
		`SFFE_CHK("first level", ~p, first_lvl)
		if (!two) `SFFE_CHK("select low", (2 * n + 2) * 4, low_len)
		`SFFE_CHK("tx idle", 1'b0, serial_tx_line)
		`SFFE_CHK("tx oe", 1'b1, serial_tx_oe)
		`SFFE_CHK("fss oe", 1'b1, frame_select_oe)
		`SFFE_CHK("sclk end", p, serial_clock_out)
		`SFFE_CHK("slave got", (two ? w ^ mk : w) & mk, got & mk)
		rd_chk(`SFFE_OFS_STAT, 32'h7, OK);
		rd_chk(`SFFE_OFS_DATA, {16'h0, REPLY & mk}, OK);
	endtask

	initial begin
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		`SFFE_CHK("reset fss", 1'b1, frame_select_out)
		`SFFE_CHK("reset tx", 1'b0, serial_tx_line)
		`SFFE_CHK("reset sclk", 1'b0, serial_clock_out)
		rd_chk(`SFFE_OFS_STAT, 32'h3, OK);
		rd_chk(12'h014, 32'h0, `SFFE_RESP_SLVERR);
		axi_wr(12'h018, 32'h5, `SFFE_RESP_SLVERR);
		frame_test(1'b0, 1'b0, 5'd8, 8'h08, 8'h00, 16'h00A5, 1'b0);
		frame_test(1'b0, 1'b1, 5'd4, 8'h08, 8'h00, 16'h000B, 1'b0);
		frame_test(1'b1, 1'b0, 5'd16, 8'h04, 8'h01, 16'hA5C3, 1'b0);
		frame_test(1'b1, 1'b1, 5'd5, 8'h02, 8'h03, 16'h0013, 1'b0);
		frame_test(1'b0, 1'b0, 5'd8, 8'h08, 8'h00, 16'h003C, 1'b1);
		frame_test(1'b1, 1'b1, 5'd6, 8'h08, 8'h00, 16'h0029, 1'b1);
		// slave role: the partner becomes the far master, clocked by the bench
		m_pol <= 1'b0;
		m_pha <= 1'b0;
		m_n <= 5'd8;
		axi_wr(`SFFE_OFS_CTRL1, 32'h0, OK);
		axi_wr(`SFFE_OFS_CTRL0, 32'h7, OK);
		axi_wr(`SFFE_OFS_DATA, 32'h96, OK);
		axi_wr(`SFFE_OFS_CTRL1, 32'h6, OK);
		slv <= 1'b1;
		@(posedge sys_clk);
		`SFFE_CHK("slave clock oe", 1'b0, serial_clock_oe)
		`SFFE_CHK("slave fss oe", 1'b0, frame_select_oe)
		fss_in <= 1'b0;
		repeat (16) @(posedge sys_clk);
		`SFFE_CHK("slave tx oe", 1'b1, serial_tx_oe)
		repeat (16) begin
			sclk_in <= ~sclk_in;
			repeat (8) @(posedge sys_clk);
		end
		repeat (8) @(posedge sys_clk);
		fss_in <= 1'b1;
		repeat (16) @(posedge sys_clk);
		`SFFE_CHK("slave tx word", 16'h0096, got & 16'h00FF)
		rd_chk(`SFFE_OFS_DATA, {24'h0, REPLY[7:0]}, OK);
		tally_and_finish();
	end
endmodule // sffe_engine_tb
